// ---- common/bus_arb_pkg.sv ----
package bus_arb_pkg;
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int ACC_W      = 5;     // access length field, value n means n+1 periods
    localparam int LAT_W      = 4;
    localparam int MEM_AW     = 4;
    localparam int SYS_PERIOD_NS = 100;
    localparam int BUS_PERIOD_NS = 200;
    localparam int BUS_HALF_CYC  = BUS_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [ACC_W-1:0] ACC_ZERO = 5'h00;
    localparam logic [LAT_W-1:0] LAT_ZERO = 4'h0;
endpackage

// ---- common/ext_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface ext_bus_if;
    import bus_arb_pkg::*;
    logic              bus_clock_output;
    logic              ale;
    logic [ADDR_W-1:0] addr_o;
    logic              rd_n_o;
    logic              wr_n_o;
    logic              ctl_oe_n;
    logic [DATA_W-1:0] dat_dev_o;
    logic              dat_dev_oe_n;
    logic [DATA_W-1:0] dat_ext_o;
    logic              dat_ext_oe_n;
    logic              ready;
    logic              hold_n;
    logic              hold_acknowledge_out;
    logic              bus_request_out;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;

    // weak pull-ups when nobody drives
    assign rd_n = ctl_oe_n ? 1'b1 : rd_n_o;
    assign wr_n = ctl_oe_n ? 1'b1 : wr_n_o;
    assign addr = ctl_oe_n ? {ADDR_W{1'b1}} : addr_o;
    assign data = !dat_dev_oe_n ? dat_dev_o : (!dat_ext_oe_n ? dat_ext_o : {DATA_W{1'b1}});

    modport dev (output bus_clock_output, ale, addr_o, rd_n_o, wr_n_o, ctl_oe_n,
                 dat_dev_o, dat_dev_oe_n, hold_acknowledge_out, bus_request_out,
                 input ready, hold_n, data);
    modport ext (input bus_clock_output, ale, addr, rd_n, wr_n, data,
                 hold_acknowledge_out, bus_request_out,
                 output ready, hold_n, dat_ext_o, dat_ext_oe_n);
endinterface
`default_nettype wire

// ---- rtl/ext_bus_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctrl
    import bus_arb_pkg::*;
(
    input  wire logic              sys_clk,     // 10 MHz system clock
    input  wire logic              srst,        // synchronous reset, high
    input  wire logic              req,         // start a cycle, taken when not busy
    input  wire logic              we,          // cycle is a write
    input  wire logic [ADDR_W-1:0] addr,        // cycle address
    input  wire logic [DATA_W-1:0] wdata,       // write data
    input  wire logic              ready_en,    // access phase ends by ready
    input  wire logic              ready_async, // asynchronous ready mode
    input  wire logic              ready_pol,   // active level of ready
    input  wire logic              arb_en,      // arbitration signals enabled
    input  wire logic [ACC_W-1:0]  access_phase_length, // access periods minus one
    input  wire logic              own_req,     // want bus back while released
    output logic [DATA_W-1:0]      rdata,       // read data
    output logic                   done,        // one-cycle pulse at cycle end
    output logic                   busy,        // cycle pending or running
    output logic                   released,    // bus handed to other master
    ext_bus_if.dev                 bus          // external bus pins
);
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ADDR   = 6'b000010,
        ST_ACCESS = 6'b000100,
        ST_OFF    = 6'b001000,
        ST_HELD   = 6'b010000,
        ST_REGAIN = 6'b100000
    } state_type;

    // pin synchronisers
    logic              rdy_s1_reg, rdy_s2_reg, rdy_s3_reg, rdy_s3_next;
    logic              hold_s1_reg, hold_s2_reg;
    logic [DATA_W-1:0] dat_s1_reg, dat_s2_reg;

    state_type         state_reg, state_next;
    logic              bclk_reg, bclk_next;
    logic [ACC_W-1:0]  cnt_reg, cnt_next;
    logic              first_reg, first_next;
    logic              pend_reg, pend_next;
    logic              we_reg, we_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              done_reg, done_next;
    logic              rd_reg, rd_next;
    logic              wr_reg, wr_next;
    logic              float_reg, float_next;
    logic              doe_reg, doe_next;
    logic              ale_reg, ale_next;
    logic              hold_acknowledge_out_reg, hold_acknowledge_out_next;
    logic              bus_request_out_reg, bus_request_out_next;
    logic              seen_reg, seen_next;

    logic tick;
    logic hold_active;
    logic rdy_sample;

    assign tick        = !bclk_reg;   // bus clock rises on this edge
    assign hold_active = !hold_s2_reg;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdy_s1_reg  <= 1'b0;
            rdy_s2_reg  <= 1'b0;
            rdy_s3_reg  <= 1'b0;
            hold_s1_reg <= 1'b1;
            hold_s2_reg <= 1'b1;
            dat_s1_reg  <= {DATA_W{1'b0}};
            dat_s2_reg  <= {DATA_W{1'b0}};
        end
        else
        begin
            rdy_s1_reg  <= bus.ready;
            rdy_s2_reg  <= rdy_s1_reg;
            rdy_s3_reg  <= rdy_s3_next;
            hold_s1_reg <= bus.hold_n;
            hold_s2_reg <= hold_s1_reg;
            dat_s1_reg  <= bus.data;
            dat_s2_reg  <= dat_s1_reg;
        end
    end

    always_comb
    begin
        // extra stage clocked by the bus clock
        rdy_s3_next = tick ? rdy_s2_reg : rdy_s3_reg;
        rdy_sample  = ready_async ? rdy_s3_reg : rdy_s2_reg;
    end

    always_comb
    begin
        state_next = state_reg;
        bclk_next  = !bclk_reg;
        cnt_next   = cnt_reg;
        first_next = first_reg;
        pend_next  = pend_reg;
        we_next    = we_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next  = 1'b0;
        rd_next    = rd_reg;
        wr_next    = wr_reg;
        float_next = float_reg;
        doe_next   = doe_reg;
        ale_next   = ale_reg;
        hold_acknowledge_out_next  = hold_acknowledge_out_reg;
        bus_request_out_next  = bus_request_out_reg;
        seen_next  = seen_reg;
        if (req && !pend_reg)
        begin
            pend_next  = 1'b1;
            we_next    = we;
            addr_next  = addr;
            wdata_next = wdata;
        end
        if (tick)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (arb_en && hold_active)
                    begin
                        state_next = ST_OFF;
                    end
                    else if (pend_reg)
                    begin
                        ale_next   = 1'b1;
                        state_next = ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    ale_next   = 1'b0;
                    rd_next    = we_reg;
                    wr_next    = !we_reg;
                    doe_next   = we_reg;
                    // sample point set by access length
                    cnt_next   = access_phase_length;
                    first_next = 1'b1;
                    state_next = ST_ACCESS;
                end
                ST_ACCESS:
                begin
                    if (cnt_reg != ACC_ZERO)
                    begin
                        cnt_next = cnt_reg - 5'h01;
                    end
                    else if (ready_en && ready_async && first_reg)
                    begin
                        first_next = 1'b0;
                    end
                    else if (ready_en && (rdy_sample != ready_pol))
                    begin
                        first_next = 1'b0;
                    end
                    else
                    begin
                        rdata_next = we_reg ? rdata_reg : dat_s2_reg;
                        rd_next    = 1'b1;
                        wr_next    = 1'b1;
                        doe_next   = 1'b0;
                        done_next  = 1'b1;
                        pend_next  = 1'b0;
                        // release only after the cycle ends
                        state_next = ST_IDLE;
                    end
                end
                ST_OFF:
                begin
                    // strobes were driven high, now float
                    float_next = 1'b1;
                    hold_acknowledge_out_next  = 1'b0;
                    seen_next  = 1'b0;
                    state_next = ST_HELD;
                end
                ST_HELD:
                begin
                    // request waits two periods after release
                    seen_next = 1'b1;
                    // request raised while hold still active
                    bus_request_out_next = !(seen_reg && own_req);
                    if (!hold_active)
                    begin
                        hold_acknowledge_out_next  = 1'b1;
                        bus_request_out_next  = 1'b1;
                        state_next = ST_REGAIN;
                    end
                end
                ST_REGAIN:
                begin
                    // drive strobes inactive before own cycle
                    float_next = 1'b0;
                    state_next = ST_IDLE;
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            bclk_reg  <= 1'b0;
            cnt_reg   <= ACC_ZERO;
            first_reg <= 1'b0;
            pend_reg  <= 1'b0;
            we_reg    <= 1'b0;
            addr_reg  <= {ADDR_W{1'b0}};
            wdata_reg <= {DATA_W{1'b0}};
            rdata_reg <= {DATA_W{1'b0}};
            done_reg  <= 1'b0;
            rd_reg    <= 1'b1;
            wr_reg    <= 1'b1;
            float_reg <= 1'b0;
            doe_reg   <= 1'b0;
            ale_reg   <= 1'b0;
            hold_acknowledge_out_reg  <= 1'b1;
            bus_request_out_reg  <= 1'b1;
            seen_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bclk_reg  <= bclk_next;
            cnt_reg   <= cnt_next;
            first_reg <= first_next;
            pend_reg  <= pend_next;
            we_reg    <= we_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg  <= done_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            float_reg <= float_next;
            doe_reg   <= doe_next;
            ale_reg   <= ale_next;
            hold_acknowledge_out_reg  <= hold_acknowledge_out_next;
            bus_request_out_reg  <= bus_request_out_next;
            seen_reg  <= seen_next;
        end
    end

    assign bus.bus_clock_output     = bclk_reg;
    assign bus.ale                  = ale_reg;
    assign bus.addr_o               = addr_reg;
    assign bus.rd_n_o               = rd_reg;
    assign bus.wr_n_o               = wr_reg;
    assign bus.ctl_oe_n             = float_reg;
    assign bus.dat_dev_o            = wdata_reg;
    assign bus.dat_dev_oe_n         = !doe_reg;
    assign bus.hold_acknowledge_out = hold_acknowledge_out_reg;
    assign bus.bus_request_out      = bus_request_out_reg;
    assign rdata    = rdata_reg;
    assign done     = done_reg;
    assign busy     = pend_reg;
    assign released = !hold_acknowledge_out_reg;
endmodule
`default_nettype wire

// ---- rtl/ext_bus_target.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_bus_target
    import bus_arb_pkg::*;
(
    input  wire logic             sys_clk,       // system clock
    input  wire logic             srst,          // synchronous reset, high
    input  wire logic             ready_pol,     // active level of ready
    input  wire logic [LAT_W-1:0] latency,       // bus clock rises before ready
    input  wire logic             want_bus,      // ask for the bus
    input  wire logic             yield_on_bus_request_out, // give back when requested
    output logic                  granted,       // bus owned by this side
    ext_bus_if.ext                bus            // external bus pins
);
    logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

    logic              bc_s1_reg, bc_s2_reg, bc_s3_reg;
    logic              rd_s1_reg, rd_s2_reg;
    logic              wr_s1_reg, wr_s2_reg, wr_d_reg;
    logic              ack_s1_reg, ack_s2_reg;
    logic              brq_s1_reg, brq_s2_reg;
    logic [ADDR_W-1:0] a_s1_reg, a_s2_reg;
    logic [DATA_W-1:0] d_s1_reg, d_s2_reg;

    logic [LAT_W-1:0]  lat_reg, lat_next;
    logic              act_reg, act_next;
    logic [DATA_W-1:0] wbuf_reg, wbuf_next;
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic              doe_reg, doe_next;
    logic              hold_reg, hold_next;
    logic              commit;
    logic              strobe;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bc_s1_reg  <= 1'b0;
            bc_s2_reg  <= 1'b0;
            bc_s3_reg  <= 1'b0;
            rd_s1_reg  <= 1'b1;
            rd_s2_reg  <= 1'b1;
            wr_s1_reg  <= 1'b1;
            wr_s2_reg  <= 1'b1;
            wr_d_reg   <= 1'b1;
            ack_s1_reg <= 1'b1;
            ack_s2_reg <= 1'b1;
            brq_s1_reg <= 1'b1;
            brq_s2_reg <= 1'b1;
            a_s1_reg   <= {ADDR_W{1'b0}};
            a_s2_reg   <= {ADDR_W{1'b0}};
            d_s1_reg   <= {DATA_W{1'b0}};
            d_s2_reg   <= {DATA_W{1'b0}};
        end
        else
        begin
            bc_s1_reg  <= bus.bus_clock_output;
            bc_s2_reg  <= bc_s1_reg;
            bc_s3_reg  <= bc_s2_reg;
            rd_s1_reg  <= bus.rd_n;
            rd_s2_reg  <= rd_s1_reg;
            wr_s1_reg  <= bus.wr_n;
            wr_s2_reg  <= wr_s1_reg;
            wr_d_reg   <= wr_s2_reg;
            ack_s1_reg <= bus.hold_acknowledge_out;
            ack_s2_reg <= ack_s1_reg;
            brq_s1_reg <= bus.bus_request_out;
            brq_s2_reg <= brq_s1_reg;
            a_s1_reg   <= bus.addr;
            a_s2_reg   <= a_s1_reg;
            d_s1_reg   <= bus.data;
            d_s2_reg   <= d_s1_reg;
        end
    end

    assign strobe = !rd_s2_reg || !wr_s2_reg;
    assign commit = wr_s2_reg && !wr_d_reg;

    always_comb
    begin
        lat_next  = lat_reg;
        act_next  = act_reg;
        wbuf_next = !wr_s2_reg ? d_s2_reg : wbuf_reg;
        dout_next = mem[a_s2_reg[MEM_AW-1:0]];
        doe_next  = !rd_s2_reg;
        if (!strobe)
        begin
            // drop ready once strobe has risen
            // so it is clear before the next sample point
            lat_next = LAT_ZERO;
            act_next = 1'b0;
        end
        // ready changes just after a bus clock rise
        else if (bc_s2_reg && !bc_s3_reg)
        begin
            if (lat_reg != latency)
            begin
                lat_next = lat_reg + 4'h1;
            end
            else
            begin
                // held until strobe rises, over a bus period
                act_next = 1'b1;
            end
        end
        // may return the bus with no request seen
        // yields on a request while owning the bus
        hold_next = !(want_bus && !(yield_on_bus_request_out && !brq_s2_reg && !ack_s2_reg));
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lat_reg  <= LAT_ZERO;
            act_reg  <= 1'b0;
            wbuf_reg <= {DATA_W{1'b0}};
            dout_reg <= {DATA_W{1'b0}};
            doe_reg  <= 1'b0;
            hold_reg <= 1'b1;
        end
        else
        begin
            lat_reg  <= lat_next;
            act_reg  <= act_next;
            wbuf_reg <= wbuf_next;
            dout_reg <= dout_next;
            doe_reg  <= doe_next;
            hold_reg <= hold_next;
        end
    end

    // storage has no reset; contents are undefined until written
    always_ff @(posedge sys_clk)
    begin
        if (commit)
        begin
            mem[a_s2_reg[MEM_AW-1:0]] <= wbuf_reg;
        end
    end

    // hold request active low, grant seen on acknowledge
    assign bus.hold_n       = hold_reg;
    assign bus.ready        = act_reg ? ready_pol : !ready_pol;
    assign bus.dat_ext_o    = dout_reg;
    assign bus.dat_ext_oe_n = !doe_reg;
    assign granted          = !hold_reg && !ack_s2_reg;
endmodule
`default_nettype wire

// ---- tb/ext_bus_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_bus_chk (
    input wire logic sys_clk,              // system clock
    input wire logic srst,                 // synchronous reset
    input wire logic bus_clock_output,     // bus reference clock
    input wire logic ale,                  // address latch strobe
    input wire logic rd_n,                 // resolved read strobe
    input wire logic wr_n,                 // resolved write strobe
    input wire logic ctl_oe_n,             // device drives controls when low
    input wire logic hold_n,               // hold request, low active
    input wire logic hold_acknowledge_out, // hold granted, low active
    input wire logic bus_request_out       // take-back request, low active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_clk_toggles: assert property (!$past(srst) |-> bus_clock_output != $past(bus_clock_output))
        else $error("bus clock missed a toggle");
    a_strobe_on_tick: assert property (($rose(rd_n) || $rose(wr_n)) |-> $rose(bus_clock_output))
        else $error("strobe ended off a bus clock rise");
    a_release_order: assert property ($rose(ctl_oe_n) |-> $past(rd_n) && $past(wr_n) && !ale)
        else $error("controls floated before driven inactive");
    a_ack_floats: assert property (!hold_acknowledge_out |-> ctl_oe_n && !ale)
        else $error("controls driven while bus handed over");
    a_ale_driven: assert property (ale |-> !ctl_oe_n && rd_n && wr_n)
        else $error("latch strobe high outside address period");
    a_bus_request_out_held_only: assert property (!bus_request_out |-> !hold_acknowledge_out && $past(!hold_acknowledge_out))
        else $error("bus request outside released state");
    a_ack_on_hold: assert property ($fell(hold_acknowledge_out) |-> $past(!hold_n, 2))
        else $error("acknowledge without hold request");
    a_ack_held: assert property (!hold_acknowledge_out && !hold_n && $past(!hold_n) && $past(!hold_n, 2) |=> !hold_acknowledge_out)
        else $error("acknowledge dropped while hold still asked");
    a_ack_returns: assert property (hold_n |-> ##[0:12] hold_acknowledge_out)
        else $error("bus not taken back after hold withdrawn");
    a_regain_order: assert property ($fell(ctl_oe_n) |-> hold_acknowledge_out && rd_n && wr_n && !ale)
        else $error("regain drove an active control");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
    import bus_arb_pkg::*;
    logic              sys_clk = 1'b0;
    logic              srst = 1'b1;
    logic              req = 1'b0, we = 1'b0, ready_en = 1'b0, ready_async = 1'b0;
    logic              ready_pol = 1'b1, arb_en = 1'b0, own_req = 1'b0;
    logic              want_bus = 1'b0, yield_on_bus_request_out = 1'b0;
    logic              done, busy, released, granted;
    logic [ADDR_W-1:0] addr_v = 16'h0000;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic [DATA_W-1:0] rd_data;
    logic [ACC_W-1:0]  acc_len = 5'h00;
    logic [LAT_W-1:0]  latency = 4'h0;
    int                num_errors = 0, checked = 0, cyc = 0, n, acc;
    int                acc_tab [4][2];
    time               t_ale = 0;

    ext_bus_if link ();
    ext_bus_ctrl ext_bus_ctrl_i (.sys_clk(sys_clk), .srst(srst), .req(req), .we(we),
        .addr(addr_v), .wdata(wdata), .ready_en(ready_en), .ready_async(ready_async),
        .ready_pol(ready_pol), .arb_en(arb_en), .access_phase_length(acc_len),
        .own_req(own_req), .rdata(rd_data), .done(done), .busy(busy),
        .released(released), .bus(link));
    ext_bus_target ext_bus_target_i (.sys_clk(sys_clk), .srst(srst), .ready_pol(ready_pol),
        .latency(latency), .want_bus(want_bus), .yield_on_bus_request_out(yield_on_bus_request_out),
        .granted(granted), .bus(link));
    ext_bus_chk ext_bus_chk_i (.sys_clk(sys_clk), .srst(srst),
        .bus_clock_output(link.bus_clock_output), .ale(link.ale), .rd_n(link.rd_n),
        .wr_n(link.wr_n), .ctl_oe_n(link.ctl_oe_n), .hold_n(link.hold_n),
        .hold_acknowledge_out(link.hold_acknowledge_out),
        .bus_request_out(link.bus_request_out));

    always #50 sys_clk = ~sys_clk;
    // access phase starts where the latch strobe falls
    always @(negedge link.ale) t_ale = $time;

    task automatic conclude();
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // one whole cycle; acc is access length in sys_clk cycles
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output int acc_o);
        int k;
        k = 0;
        req = 1'b1;
        we = w;
        addr_v = a;
        wdata = d;
        step(1);
        req = 1'b0;
        while (done !== 1'b1 && k < 500)
        begin
            step(1);
            k++;
        end
        `CHK(done, 1'b1);
        acc_o = int'(($time - 1 - t_ale) / 100);
    endtask

    initial
    begin
        step(6);
        srst = 1'b0;
        step(1);
        for (int k = 0; k < 2; k++)
        begin
            // target data needs five clocks after the strobe: fixed access of 2 or more
            acc_len = (k == 0) ? 5'h02 : 5'h03;
            xfer(1'b1, 16'h0003 + k, 16'hbee0 + k, acc);
            `CHK(acc, 2 * (int'(acc_len) + 1));
            xfer(1'b0, 16'h0003 + k, 16'h0000, acc);
            `CHK(rd_data, 16'hbee0 + k);
        end
        // every polarity and mode, short and long ready latency
        ready_en = 1'b1;
        acc_len = 5'h01;
        for (int m = 0; m < 4; m++)
        begin
            ready_pol = m[0];
            ready_async = m[1];
            step(4);
            `CHK(link.ready, ~ready_pol);
            for (int l = 0; l < 2; l++)
            begin
                latency = (l == 0) ? 4'h0 : 4'h3;
                xfer(1'b1, 16'h0008 + m, 16'h5a00 + 2 * m + l, acc);
                xfer(1'b0, 16'h0008 + m, 16'h0000, acc_tab[m][l]);
                `CHK(rd_data, 16'h5a00 + 2 * m + l);
            end
            `CHK(acc_tab[m][1] > acc_tab[m][0], 1'b1);
            `CHK(acc_tab[m][0] >= 4, 1'b1);
            if (m >= 2)
            begin
                `CHK(acc_tab[m][0] > acc_tab[m - 2][0], 1'b1);
                `CHK(acc_tab[m][0] >= 6, 1'b1);
            end
        end
        // hold asked while arbitration is off
        ready_pol = 1'b1;
        ready_async = 1'b0;
        want_bus = 1'b1;
        step(20);
        `CHK(released, 1'b0);
        `CHK(link.hold_acknowledge_out, 1'b1);
        // enable arbitration in mid-cycle: the cycle must finish first
        latency = 4'h8;
        req = 1'b1;
        we = 1'b0;
        addr_v = 16'h0003;
        step(1);
        req = 1'b0;
        for (n = 0; n < 60 && link.ale !== 1'b1; n++) step(1);
        arb_en = 1'b1;
        for (n = 0; n < 200 && done !== 1'b1; n++) step(1);
        `CHK(done, 1'b1);
        `CHK(released, 1'b0);
        `CHK(rd_data, 16'hbee0);
        for (n = 0; n < 60 && released !== 1'b1; n++) step(1);
        `CHK(released, 1'b1);
        // acknowledge reaches the other end through two flops
        step(2);
        `CHK(granted, 1'b1);
        `CHK(link.ale, 1'b0);
        `CHK(link.rd_n, 1'b1);
        // a cycle asked while the bus is away must wait
        ready_en = 1'b0;
        acc_len = 5'h02;
        req = 1'b1;
        addr_v = 16'h0004;
        step(1);
        req = 1'b0;
        step(30);
        `CHK(busy, 1'b1);
        `CHK(link.bus_request_out, 1'b1);
        own_req = 1'b1;
        yield_on_bus_request_out = 1'b1;
        for (n = 0; n < 60 && link.hold_n !== 1'b1; n++) step(1);
        want_bus = 1'b0;
        `CHK(link.hold_n, 1'b1);
        `CHK(link.bus_request_out, 1'b0);
        for (n = 0; n < 100 && done !== 1'b1; n++) step(1);
        `CHK(done, 1'b1);
        `CHK(rd_data, 16'hbee1);
        own_req = 1'b0;
        yield_on_bus_request_out = 1'b0;
        // other master returns the bus unasked
        want_bus = 1'b1;
        for (n = 0; n < 60 && released !== 1'b1; n++) step(1);
        step(10);
        `CHK(link.bus_request_out, 1'b1);
        want_bus = 1'b0;
        for (n = 0; n < 60 && released !== 1'b0; n++) step(1);
        `CHK(released, 1'b0);
        xfer(1'b0, 16'h0004, 16'h0000, acc);
        `CHK(rd_data, 16'hbee1);
        conclude();
    end
endmodule
`default_nettype wire
